// >>> ldsw_pkg.sv
package ldsw_pkg;

  // ==========================================================
  // Word geometry
  localparam int unsigned WORD_BITS    = 36;
  localparam int unsigned LEVEL_BITS   = 10;
  localparam int unsigned OUTS_PER_BANK = 8;
  localparam int unsigned DIV_BITS     = 4;
  localparam int unsigned COARSE_BITS  = 4;
  localparam int unsigned REV_BITS     = 3;
  localparam int unsigned FILL_BITS    = 15;

  // ==========================================================
  // Fixed values
  localparam logic [FILL_BITS-1:0] FILLER_PATTERN = 15'h2aaa;
  localparam logic [REV_BITS-1:0]  REVISION_CODE  = 3'h5; // Arbitrary value

  // ==========================================================
  // Timing
  localparam int unsigned CLK_FREQ_MHZ  = 50;
  localparam int unsigned WD_TIMEOUT_US = 200;
  localparam int unsigned WD_CYCLES     = WD_TIMEOUT_US * CLK_FREQ_MHZ;

  // ==========================================================
  // Control word, bit 36 at the top
  typedef struct packed {
    logic [COARSE_BITS-1:0] coarse_b;
    logic [COARSE_BITS-1:0] coarse_a;
    logic [DIV_BITS-1:0]    divide;
    logic                   wd_disable;
    logic [LEVEL_BITS-1:0]  level_b;
    logic [LEVEL_BITS-1:0]  level_a;
    logic [2:0]             addr;
  } ldsw_ctrl_t;

  // Status word, bit 36 at the top
  typedef struct packed {
    logic [FILL_BITS-1:0]     filler;
    logic [REV_BITS-1:0]      revision;
    logic                     thermal;
    logic                     wd_timeout;
    logic [OUTS_PER_BANK-1:0] load_ok_b;
    logic [OUTS_PER_BANK-1:0] load_ok_a;
  } ldsw_status_t;

endpackage

// >>> ldsw_pwm.sv
`timescale 1ns/100ps
module ldsw_pwm #(
  parameter int unsigned N = 16,
  parameter int unsigned W = 10
) (
  // Clock and reset
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  // Control
  input  wire logic           tick,
  input  wire logic [N*W-1:0] levels,
  input  wire logic           force_off,
  // Sinks
  output logic [N-1:0]        sink_on
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic [N-1:0] on_r;
  logic [N-1:0] on_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (tick)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Compare per output
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_cmp
      assign on_nxt[g] = ~force_off & (cnt_r <= levels[g*W +: W]); // (R12) (R14)
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      on_r  <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      on_r  <= on_nxt;
    end
  end

  assign sink_on = on_r;

endmodule

// >>> ldsw_top.sv
`timescale 1ns/100ps
// Summary of operation
// (R1) Control word: address 1-3, level A 4-13, level B 14-23, divide 25-28, coarse 29-36.
// (R2) Control bit 24 set disables the clock-loss watchdog.
// (R3) Status bits 19-21 carry a three-bit revision code.
// (R4) Status bits 1-8 flag bank A outputs, zero meaning open circuit.
// (R5) Status bits 9-16 flag bank B outputs, same polarity.
// (R6) Status bit 17 reads one after a watchdog timeout.
// (R7) Status bit 18 reads one while over-temperature is detected.
// (R8) Status bits 22-36 are alternating filler, bit 22 zero, bit 36 zero.
// (R9) Watchdog trips without shift clock edges for its timeout, 25 to 200 us.
// (R10) Strobe low: 36-bit shift register, bit 36 first, data in to out.
// (R11) Strobe high: shifting stops, first fall loads control, next rise loads status.
// (R12) Output off while the free-running 10-bit count exceeds its level.
// (R13) PWM clock is shift clock divided by divide code plus one.
// (R14) Watchdog or thermal fault forces all sinks off until it clears.
module ldsw_top #(
  parameter int unsigned                     WD_CYCLES = ldsw_pkg::WD_CYCLES,
  parameter logic [ldsw_pkg::REV_BITS-1:0]   REVISION  = ldsw_pkg::REVISION_CODE
) (
  // Clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_n,
  // Serial word port
  input  wire logic                                  serial_shift_clock,
  input  wire logic                                  serial_data_in,
  input  wire logic                                  transfer_strobe,
  output logic                                       serial_data_out,
  // Sensing
  input  wire logic [ldsw_pkg::OUTS_PER_BANK-1:0]    load_ok_a,
  input  wire logic [ldsw_pkg::OUTS_PER_BANK-1:0]    load_ok_b,
  input  wire logic                                  over_temp,
  // Drive
  output logic [ldsw_pkg::OUTS_PER_BANK-1:0]         sink_on_a,
  output logic [ldsw_pkg::OUTS_PER_BANK-1:0]         sink_on_b,
  output logic [ldsw_pkg::COARSE_BITS-1:0]           coarse_a,
  output logic [ldsw_pkg::COARSE_BITS-1:0]           coarse_b
);

  localparam int unsigned NB = ldsw_pkg::OUTS_PER_BANK;
  localparam int unsigned LW = ldsw_pkg::LEVEL_BITS;

  // ==========================================================
  // State
  logic                               sck_d_r;
  logic [ldsw_pkg::WORD_BITS-1:0]     shift_r;
  logic [ldsw_pkg::WORD_BITS-1:0]     shift_nxt;
  ldsw_pkg::ldsw_ctrl_t               ctrl_r;
  ldsw_pkg::ldsw_ctrl_t               ctrl_nxt;
  logic [NB-1:0][LW-1:0]              level_a_r;
  logic [NB-1:0][LW-1:0]              level_a_nxt;
  logic [NB-1:0][LW-1:0]              level_b_r;
  logic [NB-1:0][LW-1:0]              level_b_nxt;
  logic                               copied_r;
  logic                               copied_nxt;
  logic                               captured_r;
  logic                               captured_nxt;
  logic                               armed_r;
  logic                               armed_nxt;
  logic [31:0]                        wd_cnt_r;
  logic [31:0]                        wd_cnt_nxt;
  logic                               wd_sticky_r;
  logic                               wd_sticky_nxt;
  logic                               fault_r;
  logic                               fault_nxt;
  logic [ldsw_pkg::DIV_BITS-1:0]      div_cnt_r;
  logic [ldsw_pkg::DIV_BITS-1:0]      div_cnt_nxt;
  logic                               tick_r;
  logic                               tick_nxt;

  logic                               sck_rise;
  logic                               sck_fall;
  logic                               wd_expired;
  ldsw_pkg::ldsw_ctrl_t               word_in;
  ldsw_pkg::ldsw_status_t             status_word;
  logic [2*NB-1:0]                    sinks;

  assign sck_rise = serial_shift_clock & ~sck_d_r;
  assign sck_fall = ~serial_shift_clock & sck_d_r;
  assign word_in  = ldsw_pkg::ldsw_ctrl_t'(shift_r); // (R1)
  assign wd_expired = (wd_cnt_r >= WD_CYCLES);

  // ==========================================================
  // Status word assembly
  always_comb
  begin
    status_word            = '0;
    status_word.load_ok_a  = load_ok_a;                // (R4)
    status_word.load_ok_b  = load_ok_b;                // (R5)
    status_word.wd_timeout = wd_sticky_r;              // (R6)
    status_word.thermal    = over_temp;                // (R7)
    status_word.revision   = REVISION;                 // (R3)
    status_word.filler     = ldsw_pkg::FILLER_PATTERN; // (R8)
  end

  // ==========================================================
  // Shift register and transfer sequence
  always_comb
  begin
    shift_nxt    = shift_r;
    ctrl_nxt     = ctrl_r;
    level_a_nxt  = level_a_r;
    level_b_nxt  = level_b_r;
    copied_nxt   = copied_r;
    captured_nxt = captured_r;
    armed_nxt    = armed_r;
    if (!transfer_strobe)
    begin
      copied_nxt   = 1'b0;
      captured_nxt = 1'b0;
      if (sck_rise)
      begin
        shift_nxt = {shift_r[ldsw_pkg::WORD_BITS-2:0], serial_data_in}; // (R10)
      end
    end
    else
    begin
      if (sck_fall && !copied_r)
      begin
        ctrl_nxt                 = word_in;     // (R11)
        level_a_nxt[word_in.addr] = word_in.level_a; // (R1)
        level_b_nxt[word_in.addr] = word_in.level_b; // (R1)
        copied_nxt               = 1'b1;
        armed_nxt                = 1'b1;
      end
      if (sck_rise && copied_r && !captured_r)
      begin
        shift_nxt    = status_word;             // (R11)
        captured_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_d_r    <= 1'b0;
      shift_r    <= '0;
      ctrl_r     <= '0;
      level_a_r  <= '0;
      level_b_r  <= '0;
      copied_r   <= 1'b0;
      captured_r <= 1'b0;
      armed_r    <= 1'b0;
    end
    else
    begin
      sck_d_r    <= serial_shift_clock;
      shift_r    <= shift_nxt;
      ctrl_r     <= ctrl_nxt;
      level_a_r  <= level_a_nxt;
      level_b_r  <= level_b_nxt;
      copied_r   <= copied_nxt;
      captured_r <= captured_nxt;
      armed_r    <= armed_nxt;
    end
  end

  // ==========================================================
  // Watchdog, fault and PWM clock divider
  // Timeout sits at the long end of the window, so any clock
  // faster than the slow limit never trips it.
  always_comb
  begin
    wd_cnt_nxt    = wd_cnt_r;
    wd_sticky_nxt = wd_sticky_r;
    div_cnt_nxt   = div_cnt_r;
    tick_nxt      = 1'b0;
    if (sck_rise || sck_fall)
    begin
      wd_cnt_nxt = '0;                               // (R9)
    end
    else if (!wd_expired)
    begin
      wd_cnt_nxt = wd_cnt_r + 32'h0000_0001;         // (R9)
    end
    // Cleared by the status capture, but a new trip wins
    if (transfer_strobe && sck_rise && copied_r && !captured_r)
    begin
      wd_sticky_nxt = 1'b0;
    end
    if (wd_expired && !ctrl_r.wd_disable)
    begin
      wd_sticky_nxt = 1'b1;                          // (R2) (R6)
    end
    fault_nxt = (wd_expired && !ctrl_r.wd_disable) || over_temp; // (R14)
    if (sck_rise)
    begin
      if (div_cnt_r >= ctrl_r.divide)
      begin
        div_cnt_nxt = '0;                            // (R13)
        tick_nxt    = 1'b1;
      end
      else
      begin
        div_cnt_nxt = div_cnt_r + 1'b1;              // (R13)
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wd_cnt_r    <= '0;
      wd_sticky_r <= 1'b0;
      fault_r     <= 1'b0;
      div_cnt_r   <= '0;
      tick_r      <= 1'b0;
    end
    else
    begin
      wd_cnt_r    <= wd_cnt_nxt;
      wd_sticky_r <= wd_sticky_nxt;
      fault_r     <= fault_nxt;
      div_cnt_r   <= div_cnt_nxt;
      tick_r      <= tick_nxt;
    end
  end

  // ==========================================================
  // PWM and outputs
  // Sinks stay off after reset until the first control transfer.
  ldsw_pwm #(
    .N (2*NB),
    .W (LW)
  ) u_pwm (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .tick      (tick_r),
    .levels    ({level_b_r, level_a_r}),
    .force_off (fault_r || !armed_r),
    .sink_on   (sinks)
  );

  assign sink_on_a       = sinks[NB-1:0];
  assign sink_on_b       = sinks[2*NB-1:NB];
  assign coarse_a        = ctrl_r.coarse_a;
  assign coarse_b        = ctrl_r.coarse_b;
  assign serial_data_out = shift_r[ldsw_pkg::WORD_BITS-1]; // (R10)

endmodule

// >>> ldsw_chk.sv
`timescale 1ns/100ps
module ldsw_chk #(
  parameter int unsigned WD_CYCLES = 64
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // Serial port
  input wire logic       serial_shift_clock,
  input wire logic       serial_data_in,
  input wire logic       transfer_strobe,
  input wire logic       serial_data_out,
  // Sense and drive
  input wire logic       over_temp,
  input wire logic [7:0] sink_on_a,
  input wire logic [7:0] sink_on_b,
  input wire logic [3:0] coarse_a,
  input wire logic [3:0] coarse_b
);
  // ==========================================================
  // Mirror of the shifted word
  logic [35:0] sh_r;
  logic        sc_r, hold_r, any_r, wdd_r;
  int unsigned idle_r;
  wire         up  = serial_shift_clock && !sc_r;
  wire         dn  = !serial_shift_clock && sc_r;
  wire         ld  = dn && transfer_strobe && !hold_r;
  wire         off = sink_on_a == 8'h00 && sink_on_b == 8'h00;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      sh_r   <= '0;
      sc_r   <= 1'b0;
      hold_r <= 1'b0;
      any_r  <= 1'b0;
      wdd_r  <= 1'b0;
      idle_r <= 0;
    end
    else
    begin
      sc_r   <= serial_shift_clock;
      hold_r <= transfer_strobe && (hold_r || dn);
      idle_r <= (up || dn) ? 0 : idle_r + 1;
      if (up && !transfer_strobe)
        sh_r <= {sh_r[34:0], serial_data_in};
      if (ld)
      begin
        any_r <= 1'b1;
        wdd_r <= sh_r[23];
      end
    end
  // ==========================================================
  // Properties; two-edge windows allow either detect latency
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_sdo_hold; !up && !$past(up) |=> $stable(serial_data_out); endproperty
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved");
  property p_refused; transfer_strobe && !hold_r && up |=> ##1 serial_data_out == $past(serial_data_out, 2); endproperty
  a_refused: assert property (p_refused) else $error("early rise shifted");
  property p_coarse_load; ld |-> ##2 coarse_a == sh_r[31:28] && coarse_b == sh_r[35:32]; endproperty
  a_coarse_load: assert property (p_coarse_load) else $error("coarse wrong");
  property p_coarse_hold; !ld && !$past(ld) |=> $stable(coarse_a) && $stable(coarse_b); endproperty
  a_coarse_hold: assert property (p_coarse_hold) else $error("coarse moved");
  property p_cap_filler; hold_r && up |-> ##2 !serial_data_out; endproperty
  a_cap_filler: assert property (p_cap_filler) else $error("first status bit");
  property p_hot_off; over_temp [*4] |-> off; endproperty
  a_hot_off: assert property (p_hot_off) else $error("hot sinks on");
  property p_unarmed; !any_r |-> off; endproperty
  a_unarmed: assert property (p_unarmed) else $error("sinks before load");
  property p_wd_trip; idle_r == WD_CYCLES + 4 && !wdd_r |-> off; endproperty
  a_wd_trip: assert property (p_wd_trip) else $error("watchdog idle");
endmodule

bind ldsw_top ldsw_chk #(.WD_CYCLES(WD_CYCLES)) u_chk (.*);

// >>> ldsw_ctl_model.sv
`timescale 1ns/100ps
module ldsw_ctl_model (
  // Clock
  input  wire logic clk_sys,
  // Serial bus
  input  wire logic serial_data_out,
  output logic      serial_shift_clock,
  output logic      serial_data_in,
  output logic      transfer_strobe
);
  logic [35:0] rd_word;
  event        rd_done;
  initial
  begin
    serial_shift_clock = 1'b0;
    serial_data_in     = 1'b0;
    transfer_strobe    = 1'b0;
  end
  // Three cycles a level, far inside the watchdog window
  task automatic step(input logic c);
    serial_shift_clock = c;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  // Rise before the load fall is sent on purpose
  task automatic xfer(input logic [35:0] w, input bit rd);
    for (int i = 35; i >= 0; i--)
    begin
      serial_data_in = w[i];
      step(1'b0);
      rd_word[i] = serial_data_out;
      step(1'b1);
    end
    serial_data_in = ~w[0];
    step(1'b0);
    transfer_strobe = 1'b1;
    step(1'b1);
    step(1'b0);
    step(1'b1);
    step(1'b0);
    transfer_strobe = 1'b0;
    if (rd)
      ->rd_done;
  endtask
endmodule

// >>> test_led_driver_serial_word_port.sv
`timescale 1ns/100ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module test_led_driver_serial_word_port;
  localparam int unsigned WD = 64;
  // ==========================================================
  // Signals
  logic                   clk_sys   = 1'b0;
  logic                   rst_n     = 1'b0;
  logic                   over_temp = 1'b0;
  logic [7:0]             load_ok_a = 8'h00;
  logic [7:0]             load_ok_b = 8'h00;
  logic                   serial_shift_clock, serial_data_in, transfer_strobe, serial_data_out;
  logic [7:0]             sink_on_a, sink_on_b;
  logic [3:0]             coarse_a, coarse_b, ca, cb;
  logic [2:0]             adr;
  int                     n_mismatch = 0;
  int                     num_checks = 0;
  int                     cyc        = 0;
  bit                     have       = 1'b0;
  // Far-side view of the PWM clock: level and divide code of the latest word
  logic [9:0]             lev        = 10'h000;
  logic [3:0]             dv         = 4'h0;
  logic [3:0]             cur_div    = 4'h0;
  logic [9:0]             m_cnt      = 10'h000;
  int unsigned            m_div      = 0;
  bit                     m_fell     = 1'b0;
  ldsw_pkg::ldsw_status_t pend, exp_s;
  ldsw_pkg::ldsw_status_t notes[$];
  ldsw_top #(.WD_CYCLES(WD)) u_dut (.*);
  ldsw_ctl_model u_ctl (.*);
  initial
    forever #10 clk_sys = ~clk_sys;
  task automatic give_verdict();
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // One word out; status captured now is read by the next word
  task automatic go(input logic wdd, input logic wexp);
    ldsw_pkg::ldsw_ctrl_t w;
    ca = 4'($urandom);
    cb = 4'($urandom);
    load_ok_a = 8'($urandom);
    load_ok_b = 8'($urandom);
    lev = 10'($urandom_range(31, 0));
    dv  = 4'($urandom);
    w = {cb, ca, dv, wdd, 10'h3ff, lev, adr};
    if (have)
      notes.push_back(pend);
    u_ctl.xfer(w, have);
    `CHK("coarse_a", ca, coarse_a)
    `CHK("coarse_b", cb, coarse_b)
    pend = {15'h2aaa, ldsw_pkg::REVISION_CODE, over_temp, wexp, load_ok_b, load_ok_a};
    have = 1'b1;
  endtask
  initial
    forever
    begin
      @(u_ctl.rd_done);
      exp_s = notes.pop_front();
      `CHK("status", exp_s, u_ctl.rd_word)
    end
  // ==========================================================
  // PWM count expected from the shift clock alone
  // Only the first fall under the strobe brings in a new code
  always @(negedge serial_shift_clock)
  begin
    if (transfer_strobe && !m_fell)
      cur_div = dv;
    m_fell = transfer_strobe;
  end
  always @(posedge serial_shift_clock)
  begin
    if (m_div >= cur_div)
    begin
      m_div = 0;
      m_cnt = m_cnt + 10'h001;
    end
    else
      m_div++;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(14537));
    adr = 3'($urandom);
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    go(1'b1, 1'b0);
    go(1'b0, 1'b0);
    `CHK("sink_a", m_cnt <= lev, sink_on_a[adr])
    `CHK("sink_b", 1'b1, sink_on_b[adr])
    over_temp = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1;
    `CHK("hot", 16'h0000, {sink_on_b, sink_on_a})
    go(1'b0, 1'b0);
    over_temp = 1'b0;
    go(1'b0, 1'b0);
    `CHK("cool", 1'b1, sink_on_b[adr])
    `CHK("cool_a", m_cnt <= lev, sink_on_a[adr])
    repeat (WD + 10) @(posedge clk_sys);
    #1;
    `CHK("wd_trip", 16'h0000, {sink_on_b, sink_on_a})
    go(1'b0, 1'b1);
    go(1'b1, 1'b0);
    repeat (WD + 10) @(posedge clk_sys);
    #1;
    `CHK("wd_off", 1'b1, sink_on_b[adr])
    `CHK("wd_off_a", m_cnt <= lev, sink_on_a[adr])
    go(1'b1, 1'b0);
    repeat (4) @(posedge clk_sys);
    give_verdict();
  end
endmodule
